// *** logic/adc_converter_end.sv ***
// Converter end: conversion sequencing, end-of-conversion pulse and output.
// Assumes the analog result arrives on sample_code when the conversion ends.
`timescale 1ns/1ps
`default_nettype none
module adc_converter_end (
	input wire logic core_clk,
	input wire logic reset,
	adc_link_if.device link,
	input wire logic [11:0] sample_code,
	input wire logic unipolar,
	output logic track_hold,
	output logic busy
);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CONV = 3'b010,
		ST_EOC = 3'b100
	} conv_state_t;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [5:0] sync1_q;
	logic [5:0] sync2_q;
	logic [5:0] sync_d;
	logic conv_s_q, conv_s_d;
	logic sclk_s_q, sclk_s_d;

	// Pins pass two flops before use
	always_comb begin
		sync_d = {link.conversion_trigger_n, link.data4_or_serial_clock,
			link.data3_or_frame_sync, link.mode, link.rd_n, link.cs_n};
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			// Idle levels: serial clock low, every strobe high
			sync1_q <= 6'h2F;
			sync2_q <= 6'h2F;
			conv_s_q <= 1'b1;
			sclk_s_q <= 1'b0;
		end else begin
			sync1_q <= sync_d;
			sync2_q <= sync1_q;
			conv_s_q <= conv_s_d;
			sclk_s_q <= sclk_s_d;
		end
	end

	logic conv_s, sclk_s, fs_n_s, mode_s;
	always_comb begin
		conv_s = sync2_q[5];
		sclk_s = sync2_q[4];
		fs_n_s = sync2_q[3];
		mode_s = sync2_q[2];
		conv_s_d = conv_s;
		sclk_s_d = sclk_s;
	end

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	conv_state_t state_q, state_d;
	logic [4:0] cnt_q, cnt_d;
	logic [11:0] result_q, result_d;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		result_d = result_q;
		unique case (state_q)
			ST_IDLE: begin
				if (conv_s && !conv_s_q) begin
					state_d = ST_CONV;
					cnt_d = adc_link_pkg::CONV_CYCLES;
				end
			end
			ST_CONV: begin
				if (cnt_q == 5'h01) begin
					state_d = ST_EOC;
					cnt_d = {1'b0, adc_link_pkg::EOC_CYCLES};
					// Bipolar codes flip the offset-binary sign bit
					result_d = sample_code ^ {!unipolar, 11'h000};
				end else begin
					cnt_d = cnt_q - 5'h01;
				end
			end
			ST_EOC: begin
				if (cnt_q == 5'h01) begin
					state_d = ST_IDLE;
				end else begin
					cnt_d = cnt_q - 5'h01;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q <= ST_IDLE;
			cnt_q <= 5'h00;
			result_q <= adc_link_pkg::RESULT_RESET;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			result_q <= result_d;
		end
	end

	assign link.eoc_n = (state_q != ST_EOC);
	assign track_hold = (state_q == ST_CONV);
	assign busy = (state_q != ST_IDLE);

	// ----------------------------------------------------------------
	// Serial output shift register
	// ----------------------------------------------------------------
	logic [15:0] shift_q, shift_d;
	logic [4:0] sent_q, sent_d;
	logic ser_q, ser_d;

	// Frame load while sync is high; each clock rise puts the next bit out,
	// so the bit stands on the line through the following falling edge
	always_comb begin
		shift_d = shift_q;
		sent_d = sent_q;
		ser_d = ser_q;
		if (fs_n_s) begin
			shift_d = {{adc_link_pkg::LEAD_ZEROS{1'b0}}, result_q};
			sent_d = 5'h00;
			ser_d = 1'b0;
		end else if (sclk_s && !sclk_s_q && sent_q != adc_link_pkg::FRAME_LAST) begin
			ser_d = shift_q[15];
			shift_d = {shift_q[14:0], 1'b0};
			sent_d = sent_q + 5'h01;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			shift_q <= 16'h0000;
			sent_q <= 5'h00;
			ser_q <= 1'b0;
		end else begin
			shift_q <= shift_d;
			sent_q <= sent_d;
			ser_q <= ser_d;
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	logic read_en;
	always_comb begin
		read_en = (mode_s == adc_link_pkg::MODE_PARALLEL) && !sync2_q[1] && !sync2_q[0];
		link.db_o = result_q;
		link.db_oe = {adc_link_pkg::RESULT_BITS{read_en}};
		if (mode_s == adc_link_pkg::MODE_SERIAL) begin
			// Only the serial data line drives; the rest float
			link.db_o = {6'h00, ser_q, 5'h00};
			link.db_oe = 12'h020;
		end
	end

endmodule
`default_nettype wire

// *** logic/adc_host_end.sv ***
// Host end: strap, convert start, parallel read or serial readout.
// Assumes the converter end on the same interface and the same core clock rate.
`timescale 1ns/1ps
`default_nettype none
module adc_host_end (
	input wire logic core_clk,
	input wire logic reset,
	adc_link_if.host link,
	input wire logic serial_mode,
	input wire logic start,
	output logic ready,
	output logic result_valid,
	output logic [11:0] result
);

	typedef enum logic [4:0] {
		H_IDLE = 5'b00001,
		H_WAIT = 5'b00010,
		H_READ = 5'b00100,
		H_SER = 5'b01000,
		H_DONE = 5'b10000
	} host_state_t;

	// ----------------------------------------------------------------
	// Synchronisers for returned pins
	// ----------------------------------------------------------------
	logic eoc1_q, eoc2_q, eoc_prev_q;
	logic [11:0] db1_q, db2_q;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			eoc1_q <= 1'b1;
			eoc2_q <= 1'b1;
			eoc_prev_q <= 1'b1;
			db1_q <= 12'h000;
			db2_q <= 12'h000;
		end else begin
			eoc1_q <= link.eoc_n;
			eoc2_q <= eoc1_q;
			eoc_prev_q <= eoc2_q;
			db1_q <= link.db_i;
			db2_q <= db1_q;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	host_state_t state_q, state_d;
	logic [3:0] div_q, div_d;
	logic [4:0] bits_q, bits_d;
	logic sclk_q, sclk_d;
	logic [15:0] rx_q, rx_d;
	logic [11:0] res_q, res_d;
	logic mode_q, mode_d;
	logic pend_q, pend_d;
	// Data line sampled two cycles after a fall, once it has crossed both flops
	localparam logic [3:0] SAMPLE_AT = adc_link_pkg::SCLK_HALF - 4'h2;

	always_comb begin
		state_d = state_q;
		div_d = div_q;
		bits_d = bits_q;
		sclk_d = sclk_q;
		rx_d = rx_q;
		res_d = res_q;
		mode_d = mode_q;
		pend_d = pend_q;
		unique case (state_q)
			H_IDLE: begin
				mode_d = serial_mode ? adc_link_pkg::MODE_SERIAL :
					adc_link_pkg::MODE_PARALLEL;
				if (start) begin
					state_d = H_WAIT;
				end
			end
			H_WAIT: begin
				if (!eoc2_q && eoc_prev_q) begin
					state_d = (mode_q == adc_link_pkg::MODE_SERIAL) ? H_SER : H_READ;
					div_d = 4'h0;
					bits_d = 5'h00;
					sclk_d = 1'b0;
					pend_d = 1'b0;
				end
			end
			H_READ: begin
				// Hold the read strobe until data has crossed both flops
				div_d = div_q + 4'h1;
				if (div_q == adc_link_pkg::SCLK_HALF) begin
					res_d = db2_q;
					state_d = H_DONE;
				end
			end
			H_SER: begin
				// Serial clock from a divider of the core clock
				if (div_q == adc_link_pkg::SCLK_HALF - 4'h1) begin
					div_d = 4'h0;
					sclk_d = !sclk_q;
					if (sclk_q) begin
						// Falling edge: a bit is due once it has crossed both flops
						pend_d = 1'b1;
					end
				end else begin
					div_d = div_q + 4'h1;
				end
				if (pend_q && div_q == SAMPLE_AT) begin
					rx_d = {rx_q[14:0], db2_q[5]};
					bits_d = bits_q + 5'h01;
					pend_d = 1'b0;
				end
				if (bits_q == adc_link_pkg::FRAME_LAST) begin
					// Park the clock low so no stray edge follows the frame
					res_d = rx_q[11:0];
					sclk_d = 1'b0;
					div_d = 4'h0;
					state_d = H_DONE;
				end
			end
			H_DONE: begin
				state_d = H_IDLE;
			end
			default: begin
				state_d = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q <= H_IDLE;
			div_q <= 4'h0;
			bits_q <= 5'h00;
			sclk_q <= 1'b0;
			rx_q <= 16'h0000;
			res_q <= 12'h000;
			mode_q <= adc_link_pkg::MODE_PARALLEL;
			pend_q <= 1'b0;
		end else begin
			state_q <= state_d;
			div_q <= div_d;
			bits_q <= bits_d;
			sclk_q <= sclk_d;
			rx_q <= rx_d;
			res_q <= res_d;
			mode_q <= mode_d;
			pend_q <= pend_d;
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	always_comb begin
		link.mode = mode_q;
		link.conversion_trigger_n = !(state_q == H_IDLE && start) ; // Rises next cycle
		link.rd_n = (state_q != H_READ);
		link.cs_n = (state_q != H_READ);
		link.data4_or_serial_clock = sclk_q;
		link.data3_or_frame_sync = (state_q != H_SER);
	end
	// Top two lines tied low in serial mode are resolved by the bench
	// Lines for bits two to zero are never read in serial mode

	assign ready = (state_q == H_IDLE);
	assign result_valid = (state_q == H_DONE);
	assign result = res_q;

endmodule
`default_nettype wire

// *** logic/adc_link_if.sv ***
// Interface joining the converter end and the host end.
// Assumes the bench resolves each shared pin from the output enables.
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
	logic conversion_trigger_n;
	logic eoc_n;
	logic rd_n;
	logic cs_n;
	logic mode;
	logic [11:0] db_o;
	logic [11:0] db_oe;
	logic data4_or_serial_clock;
	logic data3_or_frame_sync;
	logic [11:0] db_i;

	// Converter end
	modport device (
		input conversion_trigger_n, rd_n, cs_n, mode, data4_or_serial_clock,
		input data3_or_frame_sync, db_i,
		output eoc_n, db_o, db_oe
	);

	// Host end
	modport host (
		output conversion_trigger_n, rd_n, cs_n, mode, data4_or_serial_clock,
		output data3_or_frame_sync,
		input eoc_n, db_o, db_oe, db_i
	);
endinterface
`default_nettype wire

// *** logic/adc_link_pkg.sv ***
// Package of constants shared by both ends of the converter output link.
// Assumes a 10 MHz core clock at both ends and a slow external serial clock.
//
// Summary of operation
// - Parallel drives line as bit four; serial clock input
// - Host supplies the serial clock in serial mode
// - After frame sync low, shift on serial clock rise
// - Host drives frame sync low to request readout
// - Frame sync line is data bit three in parallel
// - Host leaves bits two to zero unconnected serially
// - Two's complement bipolar, straight binary unipolar
// - Data bit zero is the result LSB
// - Parallel data drive only while read and select low
// - End of conversion is a 100 ns low pulse
// - Rising convert start holds and begins conversion
// - Serial frame is four zeros then twelve bits
// - Host holds mode high parallel, low serial
// - Host ties the two top data lines low serially
package adc_link_pkg;

	// ----------------------------------------------------------------
	// Widths and frame layout
	// ----------------------------------------------------------------
	localparam int RESULT_BITS = 12;
	localparam int FRAME_BITS = 16;
	localparam int LEAD_ZEROS = 4;
	localparam int BIT_SCLK = 4;
	localparam int BIT_RFS = 3;
	localparam logic [4:0] FRAME_LAST = 5'h10;
	localparam logic [3:0] SIGN_POS = 4'hB;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int EOC_PULSE_NS = 100;
	localparam int EOC_CYCLES_I = (EOC_PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(EOC_PULSE_NS / CLK_PERIOD_NS);
	localparam logic [3:0] EOC_CYCLES = EOC_CYCLES_I[3:0];
	localparam logic [4:0] CONV_CYCLES = 5'h10;
	localparam logic [3:0] SCLK_HALF = 4'h4;
	localparam logic [11:0] RESULT_RESET = 12'h000;

	// ----------------------------------------------------------------
	// Interface mode strap level
	// ----------------------------------------------------------------
	localparam logic MODE_PARALLEL = 1'b1;
	localparam logic MODE_SERIAL = 1'b0;

endpackage

// *** test/adc_conversion_output_interface_test.sv ***
// Bench joining both ends of the converter output link.
// Assumes a 10 MHz core clock; the bench resolves the shared data pins.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_output_interface_test;
	logic core_clk, reset, serial_mode, start, unipolar, tog, track_hold, busy, ready, result_valid;
	logic [11:0] sample_code, result, bus, par_seen;
	logic [15:0] frame;
	logic [13:0] cases [8] = '{14'h1A5C, 14'h0000, 14'h0FFF, 14'h3801, 14'h27FE, 14'h3FFF,
		14'h1123, 14'h2000};
	int n_fail, compares, nbits;
	adc_link_if link();
	adc_converter_end adc_converter_end_inst (.core_clk(core_clk), .reset(reset), .link(link),
		.sample_code(sample_code), .unipolar(unipolar), .track_hold(track_hold), .busy(busy));
	adc_host_end adc_host_end_inst (.core_clk(core_clk), .reset(reset), .link(link),
		.serial_mode(serial_mode), .start(start), .ready(ready), .result_valid(result_valid),
		.result(result));
	adc_link_props adc_link_props_inst (.core_clk(core_clk), .reset(reset),
		.conversion_trigger_n(link.conversion_trigger_n), .eoc_n(link.eoc_n), .rd_n(link.rd_n),
		.cs_n(link.cs_n), .mode(link.mode), .db_o(link.db_o), .db_oe(link.db_oe),
		.data4_or_serial_clock(link.data4_or_serial_clock),
		.data3_or_frame_sync(link.data3_or_frame_sync));
	// Resolve the shared pins; released lines toggle, bits 4 and 3 follow host pins, top two low serially
	always_comb begin
		for (int i = 0; i < 12; i++) begin
			bus[i] = link.db_oe[i] ? link.db_o[i] : tog;
		end
		bus[4] = link.db_oe[4] ? link.db_o[4] : link.data4_or_serial_clock;
		bus[3] = link.db_oe[3] ? link.db_o[3] : link.data3_or_frame_sync;
		bus[11:10] = link.mode ? bus[11:10] : 2'b00;
	end
	assign link.db_i = bus;
	always @(posedge core_clk) begin
		tog <= ~tog;
		if (link.mode && link.db_oe == 12'hFFF) begin
			par_seen <= link.db_i;
		end
	end
	// Serial bits on the wire at each falling clock edge in a frame
	always @(negedge link.data4_or_serial_clock) begin
		if (!link.mode && !link.data3_or_frame_sync) begin
			frame <= {frame[14:0], link.db_i[5]};
			nbits <= nbits + 1;
		end
	end
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// One conversion and its readout, started as soon as the host is idle
	task automatic convert(input logic ser, input logic uni, input logic [11:0] code);
		int k;
		logic held;
		logic [11:0] exp;
		exp = uni ? code : code ^ 12'h800;
		k = 0;
		held = 1'b0;
		while (ready !== 1'b1 && k < 200) begin
			@(posedge core_clk);
			#1;
			k++;
		end
		check("ready", {15'h0, ready}, 16'h0001);
		serial_mode = ser;
		unipolar = uni;
		sample_code = code;
		par_seen = ~exp;
		nbits = 0;
		start = 1'b1;
		@(posedge core_clk);
		#1;
		start = 1'b0;
		k = 0;
		while (result_valid !== 1'b1 && k < 400) begin
			held = held | (track_hold === 1'b1);
			@(posedge core_clk);
			#1;
			k++;
		end
		check("done", {15'h0, result_valid}, 16'h0001);
		check("busy", {15'h0, busy}, 16'h0000);
		check("hold", {15'h0, held}, 16'h0001);
		check("result", {4'h0, result}, {4'h0, exp});
		if (ser) begin
			check("frame", frame, {4'h0, exp});
			check("bits", nbits[15:0], 16'h0010);
		end else begin
			check("parallel", {4'h0, par_seen}, {4'h0, exp});
		end
		$display("test serial %0b unipolar %0b code %h done", ser, uni, code);
	endtask
	initial begin
		reset = 1'b1;
		serial_mode = 1'b0;
		start = 1'b0;
		unipolar = 1'b1;
		sample_code = 12'h000;
		tog = 1'b0;
		frame = 16'h0000;
		n_fail = 0;
		compares = 0;
		nbits = 0;
		repeat (16) @(posedge core_clk);
		#1;
		reset = 1'b0;
		for (int i = 0; i < 8; i++) begin
			convert(cases[i][13], cases[i][12], cases[i][11:0]);
		end
		conclude();
	end
	// Watchdog well beyond eight conversions
	initial begin
		#1000000;
		n_fail++;
		conclude();
	end
endmodule
`default_nettype wire

// *** test/adc_link_props.sv ***
// Checker for the link between the converter end and the host end.
// Assumes one core clock and reset for both ends.
`timescale 1ns/1ps
`default_nettype none
module adc_link_props (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic conversion_trigger_n,
	input wire logic eoc_n,
	input wire logic rd_n,
	input wire logic cs_n,
	input wire logic mode,
	input wire logic [11:0] db_o,
	input wire logic [11:0] db_oe,
	input wire logic data4_or_serial_clock,
	input wire logic data3_or_frame_sync
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	logic sclk_q, sclk_d;
	logic [3:0] since_q, since_d;
	// --------
	// Cycles since the last serial clock rise
	// --------
	always_comb begin
		sclk_d = data4_or_serial_clock;
		since_d = (since_q == 4'hF) ? since_q : since_q + 4'h1;
		since_d = (sclk_d && !sclk_q) ? 4'h0 : since_d;
	end
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sclk_q <= 1'b0;
			since_q <= 4'hF;
		end else begin
			sclk_q <= sclk_d;
			since_q <= since_d;
		end
	end
	// --------
	// Properties
	// --------
	property p_eoc_pulse; $fell(eoc_n) |=> eoc_n; endproperty
	property p_answer; $rose(conversion_trigger_n) |-> ##[16:32] !eoc_n; endproperty
	property p_conv_time; $rose(conversion_trigger_n) |=> eoc_n [*8]; endproperty
	property p_gate_off; (mode && (rd_n || cs_n)) [*4] |-> db_oe == 12'h000; endproperty
	property p_par_drive; (mode && !rd_n && !cs_n) [*4] |-> db_oe == 12'hFFF; endproperty
	property p_ser_float; (!mode) [*4] |-> (db_oe & 12'hFDF) == 12'h000; endproperty
	property p_ser_oe; (!mode && !data3_or_frame_sync) [*4] |-> db_oe[5]; endproperty
	property p_shift;
		(!mode && !data3_or_frame_sync && $changed(db_o[5])) |-> since_q <= 4'h5;
	endproperty
	a_eoc_pulse: assert property (p_eoc_pulse)
		else $error("end of conversion pulse too long");
	a_answer: assert property (p_answer)
		else $error("no end of conversion after start");
	a_conv_time: assert property (p_conv_time)
		else $error("end of conversion too early");
	a_gate_off: assert property (p_gate_off)
		else $error("data driven without read and select");
	a_par_drive: assert property (p_par_drive)
		else $error("data not driven during read");
	a_ser_float: assert property (p_ser_float)
		else $error("parallel outputs driven in serial mode");
	a_ser_oe: assert property (p_ser_oe)
		else $error("serial data not driven in frame");
	a_shift: assert property (p_shift)
		else $error("serial data moved off a clock rise");
	c_eoc: cover property ($fell(eoc_n));
	c_read: cover property (mode && db_oe == 12'hFFF);
	c_frame: cover property (!mode && $fell(data3_or_frame_sync));
endmodule
`default_nettype wire
